// ---- swc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the sleep/wake controller
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// Register word indices; byte address is four times the index
`define SWC_OPTION_IDX 16'h0081
`define SWC_CONFIG_IDX 16'h2007
`define SWC_STATUS_IDX 16'h0090

// Reset value of the option register
`define SWC_OPTION_RST 8'hff

// Option register fields
`define SWC_OPT_PRESCALE_ASSIGN 3
`define SWC_OPT_PRESCALE_SEL_LO 0

// Configuration word fields
`define SWC_CFG_EXT_RESET_PIN_ENABLE 5
`define SWC_CFG_WATCHDOG_ENABLE 3
`define SWC_CFG_OSC_SELECT_HI 2

// Status register fields
`define SWC_ST_POWERDOWN_N 0
`define SWC_ST_TIMEOUT_N 1
`define SWC_ST_SLEEPING 2
`define SWC_ST_WDT_RESET 3

// Clock and instruction timing
`define SWC_CLK_HZ 25000000
`define SWC_TOSC_PER_TCY 4
`define SWC_OST_TOSC 1024

// Watchdog nominal period and its RC clock rate
`define SWC_WDT_PERIOD_US 18000
`define SWC_WDT_RC_HZ 31250

`endif

// ---- swc_pkg.sv ----
// Types shared by the sleep/wake controller
package swc_pkg;

    // Controller states, Gray coded along run-sleep-start-resume
    typedef enum logic [1:0] {
        SWC_RUN    = 2'b00,
        SWC_SLEEP  = 2'b01,
        SWC_START  = 2'b11,
        SWC_RESUME = 2'b10
    } swc_state_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [15:0] adr;
        logic [31:0] dat;
    } swc_wb_req_t;

    // Classic Wishbone answer of the slave
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } swc_wb_rsp_t;

    // Interrupt sources: edge pin, port change, timer, peripheral
    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] flag;
    } swc_irq_t;

    // Drive state of the six port pins
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } swc_port_t;

endpackage

// ---- swc_sleep_ctrl.sv ----
// Sleep entry, wake-up, watchdog and power-state flags of a small controller
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "swc_cfg.svh"

module swc_sleep_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire swc_pkg::swc_wb_req_t wb_i,
    output swc_pkg::swc_wb_rsp_t wb_o,
    input wire logic [7:0] config_word_i,
    input wire logic ext_reset_pin_n_i,
    input wire logic wdt_rc_clk_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic pc_change_i,
    input wire logic [12:0] pc_i,
    input wire swc_pkg::swc_irq_t irq_i,
    input wire logic global_irq_enable_i,
    input wire swc_pkg::swc_port_t port_i,
    output swc_pkg::swc_port_t port_o,
    output logic osc_run_o,
    output logic instr_cycle_en_o,
    output logic nop_cycle_o,
    output logic core_reset_o,
    output logic resume_o,
    output logic irq_vector_o,
    output logic [12:0] prefetch_addr_o,
    output logic powerdown_flag_n_o,
    output logic timeout_flag_n_o,
    output logic sleeping_o,
    output logic [7:0] option_o
);
    import swc_pkg::*;

    // Derived cycle counts
    localparam int OST_CYCLES = `SWC_OST_TOSC;
    localparam int WDT_TICKS = (`SWC_WDT_PERIOD_US * `SWC_WDT_RC_HZ) / 1000000;
    localparam int CFG_OSC_HI = `SWC_CFG_OSC_SELECT_HI;
    localparam int OPT_PS_LO = `SWC_OPT_PRESCALE_SEL_LO;

    swc_state_t state_q, state_d;
    logic [7:0] option_q;
    logic [7:0] config_q;
    logic pd_n_q;
    logic to_n_q;
    logic wdt_reset_seen_q;
    logic [1:0] phase_q;
    logic cyc_en;
    logic pc_chg_seen_q;
    logic nop_q;
    logic [12:0] prefetch_q;
    logic [10:0] ost_q;
    logic irq_wake_q;
    logic vec_pend_q;
    logic vec_q;
    logic resume_q;
    logic [5:0] hold_out_q;
    logic [5:0] hold_oe_q;
    logic ext_reset_pin_n_s1_q, ext_reset_pin_n_s2_q;
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic rc_tick;
    logic [6:0] pre_q;
    logic [9:0] wdt_q;
    logic pre_out;
    logic wdt_tick;
    logic wdt_timeout;
    logic wdt_clear;
    logic wdt_enabled;
    logic ext_reset;
    logic irq_pending;
    logic sleep_entry;
    logic wake_wdt;
    logic wake_irq;
    logic crystal_mode;
    logic ack_q;
    logic [31:0] rdat_q;
    logic bus_req;
    logic [13:0] word_idx;
    logic [6:0] pre_ratio_m1;

    // Reset pin passes two flops before any use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_reset_pin_n_s1_q <= 1'b1;
            ext_reset_pin_n_s2_q <= 1'b1;
        end else begin
            ext_reset_pin_n_s1_q <= ext_reset_pin_n_i;
            ext_reset_pin_n_s2_q <= ext_reset_pin_n_s1_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end else begin
            rc_s1_q <= wdt_rc_clk_i;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end

    // Rising edge of the synchronised RC clock
    assign rc_tick = rc_s2_q & ~rc_s3_q;

    // Configuration word reloaded every clock, held only in run at phase 0 while pd_n_q is low and to_n_q high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_q <= 8'h00;
        end else if (state_q == SWC_RUN && phase_q == 2'd0 && !pd_n_q && to_n_q) begin
            config_q <= config_q;
        end else begin
            config_q <= config_word_i;
        end
    end

    // Decoded configuration and wake conditions
    assign wdt_enabled = config_q[`SWC_CFG_WATCHDOG_ENABLE];
    assign crystal_mode = (config_q[CFG_OSC_HI -: 3] < 3'd3);
    assign ext_reset = config_q[`SWC_CFG_EXT_RESET_PIN_ENABLE] & ~ext_reset_pin_n_s2_q;
    assign irq_pending = |(irq_i.enable & irq_i.flag);
    assign sleep_entry = (state_q == SWC_RUN) & sleep_instr_i & ~ext_reset;
    assign wake_wdt = (state_q == SWC_SLEEP) & wdt_timeout;
    // already pending source wakes at once
    assign wake_irq = (state_q == SWC_SLEEP) & irq_pending & ~wdt_timeout;

    always_ff @(posedge clk_i) begin
        if (rst_i || ext_reset) begin
            phase_q <= 2'd0;
        end else if (osc_run_o) begin
            phase_q <= phase_q + 2'd1;
        end
    end

    assign cyc_en = osc_run_o & (phase_q == 2'(`SWC_TOSC_PER_TCY - 1));

    // cycle after a PC change runs as NOP
    always_ff @(posedge clk_i) begin
        if (rst_i || ext_reset) begin
            pc_chg_seen_q <= 1'b0;
            nop_q <= 1'b0;
        end else if (cyc_en) begin
            nop_q <= pc_chg_seen_q | pc_change_i;
            pc_chg_seen_q <= 1'b0;
        end else if (pc_change_i) begin
            pc_chg_seen_q <= 1'b1;
        end
    end

    // Sleep controller next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            SWC_RUN: begin
                if (sleep_entry) begin
                    state_d = SWC_SLEEP;
                end
            end
            SWC_SLEEP: begin
                if (wake_wdt || wake_irq) begin
                    state_d = crystal_mode ? SWC_START : SWC_RESUME;
                end
            end
            SWC_START: begin
                if (ost_q == 11'(OST_CYCLES - 1)) begin
                    state_d = SWC_RESUME;
                end
            end
            SWC_RESUME: begin
                state_d = SWC_RUN;
            end
            default: begin
                state_d = SWC_RUN;
            end
        endcase
    end

    // reset pin restarts the device in run
    always_ff @(posedge clk_i) begin
        if (rst_i || ext_reset) begin
            state_q <= SWC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Oscillator start-up counter
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != SWC_START) begin
            ost_q <= 11'd0;
        end else begin
            ost_q <= ost_q + 11'd1;
        end
    end

    assign osc_run_o = (state_q == SWC_RUN) | (state_q == SWC_RESUME);
    assign instr_cycle_en_o = cyc_en;
    assign sleeping_o = (state_q != SWC_RUN);
    assign nop_cycle_o = nop_q;

    // capture PC plus one at sleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prefetch_q <= 13'h0000;
        end else if (sleep_entry) begin
            prefetch_q <= pc_i + 13'd1;
        end
    end

    assign prefetch_addr_o = prefetch_q;

    // Remember whether an interrupt ended sleep
    always_ff @(posedge clk_i) begin
        if (rst_i || ext_reset || sleep_entry) begin
            irq_wake_q <= 1'b0;
        end else if (wake_irq) begin
            irq_wake_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || ext_reset) begin
            resume_q <= 1'b0;
            vec_pend_q <= 1'b0;
            vec_q <= 1'b0;
        end else begin
            resume_q <= (state_q == SWC_RESUME);
            vec_q <= 1'b0;
            if (state_q == SWC_RESUME) begin
                vec_pend_q <= irq_wake_q & global_irq_enable_i;
            end else if (vec_pend_q && cyc_en) begin
                vec_pend_q <= 1'b0;
                vec_q <= 1'b1;
            end
        end
    end

    assign resume_o = resume_q;
    assign irq_vector_o = vec_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_out_q <= 6'h00;
            hold_oe_q <= 6'h00;
        end else if (state_q == SWC_RUN && !sleep_entry) begin
            hold_out_q <= port_i.out;
            hold_oe_q <= port_i.oe;
        end
    end

    assign port_o.out = hold_out_q;
    assign port_o.oe = hold_oe_q;

    // clear on clear instruction and sleep
    assign wdt_clear = watchdog_clear_instr_i | sleep_entry | wake_irq | wake_wdt | ext_reset;

    assign pre_ratio_m1 = option_q[`SWC_OPT_PRESCALE_ASSIGN]
        ? 7'((8'd1 << option_q[OPT_PS_LO +: 3]) - 8'd1) : 7'd0;
    assign pre_out = rc_tick & (pre_q == pre_ratio_m1);

    // Prescaler counter on synchronised ticks
    always_ff @(posedge clk_i) begin
        if (rst_i || wdt_clear || !wdt_enabled) begin
            pre_q <= 7'd0;
        end else if (pre_out) begin
            pre_q <= 7'd0;
        end else if (rc_tick) begin
            pre_q <= pre_q + 7'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || wdt_clear || !wdt_enabled) begin
            wdt_q <= 10'd0;
        end else if (wdt_timeout) begin
            wdt_q <= 10'd0;
        end else if (pre_out) begin
            wdt_q <= wdt_q + 10'd1;
        end
    end

    assign wdt_tick = pre_out & (wdt_q == 10'(WDT_TICKS - 1));
    assign wdt_timeout = wdt_enabled & wdt_tick;

    // reset stays internal to the device
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_reset_o <= 1'b1;
        end else begin
            core_reset_o <= ext_reset | (wdt_timeout & (state_q == SWC_RUN));
        end
    end

    // Sticky record of a watchdog reset, cleared by a status write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_reset_seen_q <= 1'b0;
        end else if (wdt_timeout && state_q == SWC_RUN) begin
            wdt_reset_seen_q <= 1'b1;
        end else if (bus_req && wb_i.we && wb_i.sel[0] &&
                     word_idx == 14'(`SWC_STATUS_IDX) &&
                     wb_i.dat[`SWC_ST_WDT_RESET]) begin
            wdt_reset_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_n_q <= 1'b1;
        end else if (sleep_entry) begin
            pd_n_q <= 1'b0;
        end else if (watchdog_clear_instr_i && state_q == SWC_RUN) begin
            pd_n_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_n_q <= 1'b1;
        end else if (wdt_timeout) begin
            to_n_q <= 1'b0;
        end else if (sleep_entry || watchdog_clear_instr_i) begin
            to_n_q <= 1'b1;
        end
    end

    assign powerdown_flag_n_o = pd_n_q;
    assign timeout_flag_n_o = to_n_q;

    // Wishbone request decode
    assign bus_req = wb_i.cyc & wb_i.stb & ~ack_q;
    assign word_idx = wb_i.adr[15:2];

    // Option register, byte lane 0; pin reset restores it
    always_ff @(posedge clk_i) begin
        if (rst_i || ext_reset) begin
            option_q <= `SWC_OPTION_RST;
        end else if (bus_req && wb_i.we && wb_i.sel[0] &&
                     word_idx == 14'(`SWC_OPTION_IDX)) begin
            option_q <= wb_i.dat[7:0];
        end
    end

    assign option_o = option_q;

    // Single-wait acknowledge and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= 32'h0000_0000;
            if (bus_req && !wb_i.we) begin
                case (word_idx)
                    14'(`SWC_OPTION_IDX): rdat_q <= {24'h00_0000, option_q};
                    14'(`SWC_CONFIG_IDX): rdat_q <= {24'h00_0000, config_q};
                    14'(`SWC_STATUS_IDX): begin
                        rdat_q <= {28'h000_0000, wdt_reset_seen_q, sleeping_o,
                                   to_n_q, pd_n_q};
                    end
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_o.ack = ack_q;
    assign wb_o.dat = rdat_q;

endmodule

// ---- swc_sleep_ctrl_properties.sv ----
// Port-level assertions for the sleep/wake controller
`timescale 1ns/10ps
module swc_sleep_ctrl_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire swc_pkg::swc_wb_req_t wb_i,
    input wire swc_pkg::swc_wb_rsp_t wb_o,
    input wire logic [7:0] config_word_i,
    input wire logic ext_reset_pin_n_i,
    input wire logic sleep_instr_i,
    input wire logic [12:0] pc_i,
    input wire swc_pkg::swc_irq_t irq_i,
    input wire swc_pkg::swc_port_t port_o,
    input wire logic osc_run_o,
    input wire logic instr_cycle_en_o,
    input wire logic core_reset_o,
    input wire logic resume_o,
    input wire logic [12:0] prefetch_addr_o,
    input wire logic powerdown_flag_n_o,
    input wire logic timeout_flag_n_o,
    input wire logic sleeping_o
);
    import swc_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [11:0] off_q;
    logic [11:0] pend_q;
    wire wake_w = |(irq_i.enable & irq_i.flag);
    wire xtal_w = config_word_i[2:0] < 3'h3;
    wire take_w = sleep_instr_i && !sleeping_o && !core_reset_o && ext_reset_pin_n_i;

    // Length of the current oscillator-off stretch
    always_ff @(posedge clk_i) begin
        if (rst_i || osc_run_o) begin
            off_q <= 12'h000;
        end else if (off_q != 12'hfff) begin
            off_q <= off_q + 12'h001;
        end
    end

    // Length of the current stretch asleep with an enabled source pending
    always_ff @(posedge clk_i) begin
        if (rst_i || !(sleeping_o && !osc_run_o && wake_w)) begin
            pend_q <= 12'h000;
        end else if (pend_q != 12'hfff) begin
            pend_q <= pend_q + 12'h001;
        end
    end

    // Restart of the oscillator not caused by the reset pin
    sequence s_clean_rise;
        $rose(osc_run_o) && ext_reset_pin_n_i && $past(ext_reset_pin_n_i, 4);
    endsequence
    sequence s_sleep_take;
        take_w;
    endsequence

    sleep_cause_a: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i))
        else $error("sleep entered without strobe");
    entry_flags_a: assert property (s_sleep_take |=>
        !powerdown_flag_n_o && timeout_flag_n_o && !osc_run_o)
        else $error("flags or oscillator wrong at sleep entry");
    osc_stop_a: assert property (!osc_run_o |-> !instr_cycle_en_o)
        else $error("instruction cycle while oscillator off");
    port_hold_a: assert property (!osc_run_o && !$past(osc_run_o) |-> $stable(port_o))
        else $error("port drive changed in sleep");
    irq_wake_a: assert property (pend_q < 12'h410)
        else $error("no wake on enabled pending source");
    resume_pulse_a: assert property (s_clean_rise |=> resume_o)
        else $error("no resume pulse after wake");
    ost_wait_a: assert property (s_clean_rise |-> !xtal_w || off_q >= 12'h401)
        else $error("start-up wait too short");
    prefetch_pc_a: assert property (s_sleep_take |=>
        prefetch_addr_o == 13'($past(pc_i) + 13'h1))
        else $error("prefetch address wrong");
    cycle_gap_a: assert property (instr_cycle_en_o ##1
        (osc_run_o && !core_reset_o && ext_reset_pin_n_i) [*3] |=> instr_cycle_en_o)
        else $error("instruction cycle not every fourth clock");
    bus_ack_a: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack ##1 !wb_o.ack)
        else $error("bus ack not a single pulse");
endmodule

// ---- swc_core_model.sv ----
// Behavioural core and interrupt sources facing the sleep/wake controller
`timescale 1ns/10ps
module swc_core_model (
    input wire logic clk_i,
    input wire logic instr_cycle_en_i,
    output logic sleep_instr_o,
    output logic watchdog_clear_instr_o,
    output logic pc_change_o,
    output logic [12:0] pc_o,
    output swc_pkg::swc_irq_t irq_o,
    output logic global_irq_enable_o,
    output swc_pkg::swc_port_t port_o
);
    import swc_pkg::*;

    // Quiet core at time zero
    initial begin
        {sleep_instr_o, watchdog_clear_instr_o, pc_change_o} = 3'h0;
        pc_o = 13'h0000;
        irq_o = '0;
        global_irq_enable_o = 1'b0;
        port_o = '0;
    end

    // Program counter and random port drive per instruction cycle
    always @(posedge clk_i) begin
        if (instr_cycle_en_i) begin
            pc_o <= pc_o + 13'h0001;
            port_o <= swc_port_t'(12'($urandom));
        end
    end

    // Source enables, flags and global enable held as levels
    task automatic set_irq(input logic [3:0] en, input logic [3:0] fl, input logic g);
        irq_o <= {en, fl};
        global_irq_enable_o <= g;
    endtask

    // One instruction: 0 sleep, 1 watchdog clear, else a branch
    task automatic exec(input int kind, output logic [12:0] p);
        @(posedge clk_i iff instr_cycle_en_i);
        case (kind)
            0: sleep_instr_o <= 1'b1;
            1: watchdog_clear_instr_o <= 1'b1;
            default: pc_change_o <= 1'b1;
        endcase
        @(posedge clk_i);
        p = pc_o;
        {sleep_instr_o, watchdog_clear_instr_o, pc_change_o} <= 3'h0;
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the sleep/wake controller
`timescale 1ns/10ps
module tb_top;
    import swc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wdt_rc_clk_i = 1'b0;
    logic ext_reset_pin_n_i = 1'b1;
    logic [7:0] config_word_i = 8'h20;
    swc_wb_req_t wb_i = '0;
    swc_wb_rsp_t wb_o;
    swc_irq_t irq_i;
    swc_port_t port_i, port_o;
    logic sleep_instr_i, watchdog_clear_instr_i, pc_change_i, global_irq_enable_i;
    logic osc_run_o, instr_cycle_en_o, nop_cycle_o, core_reset_o, resume_o, irq_vector_o;
    logic powerdown_flag_n_o, timeout_flag_n_o, sleeping_o;
    logic [12:0] pc_i, prefetch_addr_o;
    logic [7:0] option_o;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int checked = 0;

    // System clock and an unrelated, faster-than-real watchdog clock
    always #20 clk_i = ~clk_i;
    always #197 wdt_rc_clk_i = ~wdt_rc_clk_i;

    swc_sleep_ctrl dut (.*);
    swc_core_model core (.clk_i(clk_i), .instr_cycle_en_i(instr_cycle_en_o),
        .sleep_instr_o(sleep_instr_i), .watchdog_clear_instr_o(watchdog_clear_instr_i),
        .pc_change_o(pc_change_i), .pc_o(pc_i), .irq_o(irq_i),
        .global_irq_enable_o(global_irq_enable_i), .port_o(port_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One classic cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d);
        int t = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: 32'(d)};
        @(posedge clk_i);
        while (wb_o.ack !== 1'b1 && t < 50) begin
            @(posedge clk_i);
            t++;
        end
        chk(t < 50, 1'b1);
        wb_i <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    // Compare each read answer with the oldest noted value
    always @(posedge clk_i) begin
        if (wb_o.ack === 1'b1 && wb_i.we === 1'b0 && exp_q.size() > 0) begin
            chk(wb_o.dat, 32'(exp_q.pop_front()));
        end
    end

    // Power-up reset with a given configuration word
    task automatic boot(input logic [7:0] c);
        config_word_i <= c;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Sleep and check the state just after entry
    task automatic doze;
        logic [12:0] p;
        core.exec(0, p);
        @(posedge clk_i);
        chk(sleeping_o, 1'b1);
        chk({powerdown_flag_n_o, timeout_flag_n_o, osc_run_o}, 3'b010);
        chk(prefetch_addr_o, 13'(p + 13'h1));
    endtask

    task automatic await(const ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // Count resume and vector pulses over the next 24 cycles
    task automatic window(output int r, output int g);
        r = 0;
        g = 0;
        repeat (24) begin
            @(posedge clk_i);
            r += int'(resume_o === 1'b1);
            g += int'(irq_vector_o === 1'b1);
        end
    endtask

    // Give up on a hang well past the expected run length
    initial begin
        #2ms;
        n_fail++;
        tally_and_finish;
    end

    initial begin
        logic [7:0] v;
        logic [12:0] p;
        int n, r, g, k;
        void'($urandom(32'h18781d69));
        boot(8'h20);
        rd(16'h0204, 8'hff);
        rd(16'h0240, 8'h03);
        v = 8'($urandom) & 8'hfe;
        bus(1'b1, 16'h0204, v);
        rd(16'h0204, v);
        chk(option_o, v);
        bus(1'b1, 16'h801c, ~config_word_i);
        rd(16'h801c, config_word_i);
        rd(16'h0100, 8'h00);
        $display("registers test done");
        // Already pending source, global enable off, crystal then other oscillator
        for (k = 0; k < 2; k++) begin
            boot(8'h20 | 8'(k * 4));
            core.set_irq(4'h1, 4'h1, 1'b0);
            doze();
            await(osc_run_o, 9000, n);
            chk(k == 0 ? n >= 1024 && n <= 1026 : n <= 2, 1'b1);
            window(r, g);
            chk(r, 32'd1);
            chk(g, 32'd0);
        end
        $display("pending wake test done");
        boot(8'h20);
        core.set_irq(4'h2, 4'h0, 1'b1);
        doze();
        repeat (36) @(posedge clk_i);
        core.set_irq(4'h2, 4'h2, 1'b1);
        await(osc_run_o, 9000, n);
        chk(n >= 1024 && n <= 1028, 1'b1);
        window(r, g);
        chk(r, 32'd1);
        chk(g, 32'd1);
        $display("interrupt wake test done");
        core.set_irq(4'h0, 4'h4, 1'b1);
        bus(1'b1, 16'h0204, v);
        doze();
        repeat (2000) @(posedge clk_i);
        chk(osc_run_o, 1'b0);
        ext_reset_pin_n_i <= 1'b0;
        window(r, g);
        chk({sleeping_o, core_reset_o, r[1:0]}, 4'b0100);
        ext_reset_pin_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(16'h0204, 8'hff);
        core.exec(2, p);
        await(nop_cycle_o, 8, n);
        chk(n < 8, 1'b1);
        $display("reset pin test done");
        boot(8'h2c);
        // Prescaler away from the watchdog so the nominal period applies
        bus(1'b1, 16'h0204, 8'h00);
        core.set_irq(4'h0, 4'h0, 1'b0);
        doze();
        await(osc_run_o, 9000, n);
        chk(n > 4000 && n < 9000, 1'b1);
        chk({powerdown_flag_n_o, timeout_flag_n_o}, 2'b00);
        await(core_reset_o, 9000, n);
        chk(n > 4000 && n < 9000, 1'b1);
        @(posedge clk_i);
        chk(timeout_flag_n_o, 1'b0);
        core.exec(1, p);
        @(posedge clk_i);
        chk({powerdown_flag_n_o, timeout_flag_n_o}, 2'b11);
        $display("watchdog test done");
        tally_and_finish;
    end
endmodule

bind swc_sleep_ctrl swc_sleep_ctrl_properties chk_u (.clk_i, .rst_i, .wb_i, .wb_o,
    .config_word_i, .ext_reset_pin_n_i, .sleep_instr_i, .pc_i, .irq_i, .port_o, .osc_run_o,
    .instr_cycle_en_o, .core_reset_o, .resume_o, .prefetch_addr_o, .powerdown_flag_n_o,
    .timeout_flag_n_o, .sleeping_o);
